// ==== vpic_pkg.sv ====
// Constants, types and field layout of the vectored priority interrupt controller.
// Notes on behaviour
// [R1] Vector equals request number plus eight.
// [R2] Trap vectors one to five, rest reserved.
// [R3] Thirty-six software registers in the controller.
// [R4] Control one: nest disable plus trap flags.
// [R5] Control two: edge polarity and table select.
// [R6] Sources set flags; only software clears.
// [R7] Each source has its own enable.
// [R8] Each source has three-bit priority field.
// [R9] Latch holds vector and new level.
// [R10] Latched level equals pending interrupt priority.
// [R11] Bit positions follow request number order.
// [R12] Status word bits 7:5 show level.
// [R13] Level top bit is software read-only.
// [R14] Level 111 disables all user interrupts.
// [R15] Top bit joins field; one disables users.
// [R16] Nest disable makes level field read-only.
// [R17] Table select moves all fetches alternate.
// [R18] Present only above level; low number wins ties.
// [R19] Reset clears all fields and level.
package vpic_pkg;
  // Source counts and storage widths.
  localparam int SRC_COUNT  = 72;
  localparam int FLAG_WORDS = 5;
  localparam int FLAG_BITS  = 80;
  localparam int PRIO_WORDS = 18;
  localparam int EXT_COUNT  = 5;
  localparam int TRAP_COUNT = 5;
  // Request numbers of the external request pins, zero to four.
  localparam int EXT_SRC [EXT_COUNT] = '{0, 20, 29, 53, 54};
  // Control one bit holding each trap, for trap vectors one to five.
  localparam int TRAP_POS [TRAP_COUNT] = '{1, 3, 2, 4, 5};
  // Sources that exist; reserved request numbers stay zero.
  localparam logic [FLAG_BITS-1:0] SRC_PRESENT = 80'h00F6_21FF_DFFF_FFFB_7FFF;
  // Vector numbering and table placement.
  localparam logic [6:0]  VEC_OFFSET   = 7'h08;
  localparam logic [23:0] IVT_BASE     = 24'h000004;
  localparam logic [23:0] ALT_OFFSET   = 24'h000100;
  localparam logic [3:0]  TRAP_LVL_TOP = 4'hF;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_GC1   = 8'h00;
  localparam logic [7:0] IDX_GC2   = 8'h01;
  localparam logic [7:0] IDX_FLAG0 = 8'h02;
  localparam logic [7:0] IDX_EN0   = 8'h07;
  localparam logic [7:0] IDX_PRIO0 = 8'h0C;
  localparam logic [7:0] IDX_PEND  = 8'h1E;
  localparam logic [7:0] IDX_SR    = 8'h1F;
  localparam logic [7:0] IDX_CORE  = 8'h20;
  localparam logic [7:0] IDX_EVST  = 8'h21;
  localparam logic [7:0] IDX_EVEN  = 8'h22;
  localparam logic [7:0] IDX_EVCLR = 8'h23;
  // Field positions inside the 16-bit registers.
  localparam int GC1_NEST_BIT = 15;
  localparam int GC1_DIV0_BIT = 6;
  localparam int GC2_ALT_BIT  = 15;
  localparam int GC2_DISI_BIT = 14;
  localparam int SR_IPL_LSB   = 5;
  localparam int CORE_MSB_BIT = 3;
  localparam int PEND_LVL_LSB = 8;
  // APB request bundle from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vpic_apb_s;
  // Core handshake: accept the presented vector, or restore a level.
  typedef struct packed {
    logic       ack;
    logic       restore;
    logic [3:0] restore_level;
  } vpic_core_s;
endpackage

// ==== vpic_ctrl.sv ====
// Vectored priority interrupt controller with APB registers.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module vpic_ctrl
  import vpic_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_reset,
  input  wire vpic_apb_s            i_apb,
  input  wire logic [SRC_COUNT-1:0] i_req,
  input  wire logic [EXT_COUNT-1:0] i_ext_pin,
  input  wire logic [TRAP_COUNT-1:0] i_trap,
  input  wire logic                 i_div_zero,
  input  wire logic                 i_disi_active,
  input  wire vpic_core_s           i_core,
  output logic [31:0]               o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  output logic                      o_pend_valid,
  output logic [6:0]                o_pend_vec,
  output logic [3:0]                o_pend_level,
  output logic [23:0]               o_vector_addr,
  output logic [3:0]                o_cpu_level,
  output logic                      o_irq
);

  // Whole controller state in one register.
  typedef struct packed {
    logic                  nest;
    logic [6:1]            trap;
    logic                  alt;
    logic [4:0]            edge_pol;
    logic [EXT_COUNT-1:0]  ext_prev;
    logic [FLAG_BITS-1:0]  flag;
    logic [FLAG_BITS-1:0]  en;
    logic [SRC_COUNT*3-1:0] prio;
    logic [6:0]            lat_vec;
    logic [3:0]            lat_lvl;
    logic [2:0]            cpu_priority_level;
    logic                  ipl_msb;
    logic [1:0]            ev_stat;
    logic [1:0]            ev_en;
    logic                  pend_valid;
    logic [6:0]            pend_vec;
    logic [3:0]            pend_lvl;
    logic [23:0]           pend_addr;
    logic                  irq;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } vpic_state_s;

  vpic_state_s s_q;  // Registered state.
  vpic_state_s s_d;  // Next state.

  // Table address of a vector, primary or alternate.
  function automatic logic [23:0] vec_addr(input logic [6:0] vec, input logic alt);
    logic [23:0] base;
    base = IVT_BASE + {16'h0000, vec, 1'b0};
    return alt ? base + ALT_OFFSET : base;  // R1 R2 R17
  endfunction

  // Current CPU level joins the read-only top bit to the field.
  logic [3:0] cpu_level;
  assign cpu_level = {s_q.ipl_msb, s_q.cpu_priority_level};  // R15

  // Request lines that set their own flag: present, and not fed by a pin.
  // The pin sources take their flag from the edge detector, so their line is ignored.
  logic [SRC_COUNT-1:0] req_ok;
  always_comb begin
    req_ok = SRC_PRESENT[SRC_COUNT-1:0];
    // External sources are masked out of the direct request set.
    for (int e = 0; e < EXT_COUNT; e++) begin
      req_ok[EXT_SRC[e]] = 1'b0;
    end
  end

  // Sources that are both flagged and enabled, watched by a_enable_gate below.
  logic [SRC_COUNT-1:0] live;
  assign live = s_q.flag[SRC_COUNT-1:0] & s_q.en[SRC_COUNT-1:0];

  // APB phase decode.
  logic       acc;
  logic       wr;
  logic [7:0] idx;
  logic       in_range;
  assign acc      = i_apb.psel & i_apb.penable;
  assign wr       = acc & s_q.pready & i_apb.pwrite;
  assign idx      = i_apb.paddr[9:2];
  assign in_range = (i_apb.paddr[11:10] == 2'b00) && (i_apb.paddr[1:0] == 2'b00);

  // Read data and decode hit for the addressed register.
  logic [15:0] rd16;
  logic        hit;
  always_comb begin
    rd16 = 16'h0000;
    hit  = in_range;
    if (idx == IDX_GC1) begin
      rd16[GC1_NEST_BIT] = s_q.nest;  // R4
      rd16[6:1]          = s_q.trap;
    end else if (idx == IDX_GC2) begin
      rd16[GC2_ALT_BIT]  = s_q.alt;  // R5
      rd16[GC2_DISI_BIT] = i_disi_active;
      rd16[4:0]          = s_q.edge_pol;
    end else if (idx >= IDX_FLAG0 && idx < IDX_EN0) begin
      rd16 = s_q.flag[(idx - IDX_FLAG0) * 16 +: 16];  // R11
    end else if (idx >= IDX_EN0 && idx < IDX_PRIO0) begin
      rd16 = s_q.en[(idx - IDX_EN0) * 16 +: 16];  // R11
    end else if (idx >= IDX_PRIO0 && idx < IDX_PEND) begin
      for (int k = 0; k < 4; k++) begin
        rd16[k*4 +: 3] = s_q.prio[((idx - IDX_PRIO0) * 4 + k) * 3 +: 3];  // R11
      end
    end else if (idx == IDX_PEND) begin
      rd16[6:0]                = s_q.lat_vec;  // R9
      rd16[PEND_LVL_LSB +: 4]  = s_q.lat_lvl;
    end else if (idx == IDX_SR) begin
      rd16[SR_IPL_LSB +: 3] = s_q.cpu_priority_level;  // R12
    end else if (idx == IDX_CORE) begin
      rd16[CORE_MSB_BIT] = s_q.ipl_msb;
    end else if (idx == IDX_EVST) begin
      rd16[1:0] = s_q.ev_stat;
    end else if (idx == IDX_EVEN) begin
      rd16[1:0] = s_q.ev_en;
    end else if (idx != IDX_EVCLR) begin
      // Unmapped index answers with an error.
      hit = 1'b0;  // R3
    end
  end

  // Next-state logic: bus writes, hardware sets, arbitration.
  always_comb begin
    logic [FLAG_BITS-1:0] set;
    logic [FLAG_BITS-1:0] fresh;
    logic [15:0]          wd;
    logic                 found;
    logic [2:0]           best_p;
    logic [6:0]           best_v;
    logic                 trap_hit;
    logic [6:0]           trap_v;
    logic [6:1]           trap_set;
    logic [2:0]           p;
    s_d      = s_q;
    set      = '0;
    fresh    = '0;
    wd       = i_apb.pwdata[15:0];
    found    = 1'b0;
    best_p   = 3'h0;
    best_v   = 7'h00;
    trap_hit = 1'b0;
    trap_v   = 7'h00;
    trap_set = '0;
    p        = 3'h0;
    // Peripheral requests set flags; external pins by edge.
    set[SRC_COUNT-1:0] = i_req;
    for (int e = 0; e < EXT_COUNT; e++) begin
      set[EXT_SRC[e]] = s_q.edge_pol[e] ? (s_q.ext_prev[e] & ~i_ext_pin[e])
                                        : (~s_q.ext_prev[e] & i_ext_pin[e]);  // R5
    end
    set           = set & SRC_PRESENT;  // R1
    s_d.ext_prev  = i_ext_pin;
    for (int t = 0; t < TRAP_COUNT; t++) begin
      trap_set[TRAP_POS[t]] = i_trap[t];  // R2
    end
    trap_set[GC1_DIV0_BIT] = i_div_zero & i_trap[3];
    // APB write at the edge where pready is sampled high.
    if (wr && in_range) begin
      if (idx == IDX_GC1) begin
        s_d.nest = wd[GC1_NEST_BIT];  // R4
        s_d.trap = wd[6:1];
      end else if (idx == IDX_GC2) begin
        s_d.alt      = wd[GC2_ALT_BIT];  // R5
        s_d.edge_pol = wd[4:0];
      end else if (idx >= IDX_FLAG0 && idx < IDX_EN0) begin
        // Writing zero clears a flag; writing one cannot set it.
        s_d.flag[(idx - IDX_FLAG0) * 16 +: 16] =
          s_q.flag[(idx - IDX_FLAG0) * 16 +: 16] & wd;  // R6
      end else if (idx >= IDX_EN0 && idx < IDX_PRIO0) begin
        s_d.en[(idx - IDX_EN0) * 16 +: 16] = wd;  // R7
      end else if (idx >= IDX_PRIO0 && idx < IDX_PEND) begin
        for (int k = 0; k < 4; k++) begin
          s_d.prio[((idx - IDX_PRIO0) * 4 + k) * 3 +: 3] = wd[k*4 +: 3];  // R8
        end
      end else if (idx == IDX_SR) begin
        if (!s_q.nest) begin
          s_d.cpu_priority_level = wd[SR_IPL_LSB +: 3];  // R12 R16
        end
      end else if (idx == IDX_EVEN) begin
        s_d.ev_en = wd[1:0];
      end else if (idx == IDX_EVCLR) begin
        s_d.ev_stat = s_q.ev_stat & ~wd[1:0];
      end
      // Core control word is read-only here, so writes are dropped.
    end
    // Hardware sets win over a clear in the same cycle.
    fresh       = set & ~s_q.flag;
    s_d.flag    = (s_d.flag | set) & SRC_PRESENT;  // R6
    s_d.en      = s_d.en & SRC_PRESENT;
    s_d.trap    = s_d.trap | trap_set;
    s_d.ev_stat = s_d.ev_stat | {|trap_set, |fresh};
    s_d.irq     = |(s_d.ev_stat & s_d.ev_en);
    // Core accepts the presented vector: level rises to its priority, or the field goes to seven with nest disable set.
    if (i_core.ack && s_q.pend_valid) begin
      s_d.ipl_msb = s_q.pend_lvl[3];
      s_d.cpu_priority_level     = s_q.nest ? 3'h7 : s_q.pend_lvl[2:0];
    end else if (i_core.restore) begin
      // Return restores the level; the top bit can only be cleared.
      s_d.ipl_msb = s_q.ipl_msb & i_core.restore_level[3];  // R13
      s_d.cpu_priority_level     = i_core.restore_level[2:0];
    end
    // User arbitration: above the level, lowest number on a tie.
    for (int i = 0; i < SRC_COUNT; i++) begin
      p = s_q.prio[i*3 +: 3];
      if (s_q.flag[i] && s_q.en[i] && ({1'b0, p} > cpu_level)) begin  // R7 R14 R18
        if (!found || p > best_p) begin
          found  = 1'b1;
          best_p = p;
          best_v = 7'(i) + VEC_OFFSET;  // R1
        end
      end
    end
    // Traps outrank user sources; lower vector is more urgent.
    for (int t = TRAP_COUNT - 1; t >= 0; t--) begin
      if (s_q.trap[TRAP_POS[t]] && (TRAP_LVL_TOP - 4'(t) > cpu_level)) begin
        trap_hit = 1'b1;
        trap_v   = 7'(t + 1);  // R2
      end
    end
    s_d.pend_valid = found | trap_hit;
    s_d.pend_vec   = trap_hit ? trap_v : best_v;
    s_d.pend_lvl   = trap_hit ? TRAP_LVL_TOP - 4'(trap_v - 7'h01)
                              : {1'b0, best_p};  // R10
    s_d.pend_addr  = vec_addr(s_d.pend_vec, s_q.alt);  // R17
    // Latch follows the pending interrupt while one is present.
    if (s_q.pend_valid) begin
      s_d.lat_vec = s_q.pend_vec;  // R9
      s_d.lat_lvl = s_q.pend_lvl;  // R10
    end
    // APB answer: one wait cycle, then ready with data.
    s_d.pready  = acc & ~s_q.pready;
    s_d.prdata  = (acc && !s_q.pready) ? {16'h0000, rd16} : 32'h0000_0000;
    s_d.pslverr = acc & ~s_q.pready & ~hit;
  end

  // State register; reset clears everything.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_q <= '0;  // R19
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign o_prdata      = s_q.prdata;
  assign o_pready      = s_q.pready;
  assign o_pslverr     = s_q.pslverr;
  assign o_pend_valid  = s_q.pend_valid;
  assign o_pend_vec    = s_q.pend_vec;
  assign o_pend_level  = s_q.pend_lvl;
  assign o_vector_addr = s_q.pend_addr;
  assign o_cpu_level   = cpu_level;
  assign o_irq         = s_q.irq;

  // A presented vector points into the selected table.
  a_vector_table: assert property (@(posedge i_clock) disable iff (i_reset)  // R1 R17
    o_pend_valid |-> o_vector_addr == vec_addr(o_pend_vec, $past(s_q.alt)))
    else $error("vector address does not match table");

  // Flags never clear without a bus write.
  a_flag_sticky: assert property (@(posedge i_clock) disable iff (i_reset)  // R6
    !wr |=> (s_q.flag & $past(s_q.flag)) == $past(s_q.flag))
    else $error("flag cleared without software write");

  // Each present peripheral request shows as its own flag one cycle later.
  a_request_sets: assert property (@(posedge i_clock) disable iff (i_reset)  // R6
    |(i_req & req_ok)
      |=> (s_q.flag[SRC_COUNT-1:0] & $past(i_req & req_ok)) == $past(i_req & req_ok))
    else $error("request did not set its flag");

  // User vectors only appear above the previous level.
  a_level_gate: assert property (@(posedge i_clock) disable iff (i_reset)  // R18 R14
    o_pend_valid && o_pend_vec >= VEC_OFFSET |-> o_pend_level > $past(cpu_level))
    else $error("user vector presented at or below level");

  // The top level bit never rises from a bus access.
  a_msb_readonly: assert property (@(posedge i_clock) disable iff (i_reset)  // R13
    !(i_core.ack && s_q.pend_valid) |=> !$rose(s_q.ipl_msb))
    else $error("level top bit set without acceptance");

  // Nest disable freezes the level field against writes.
  a_nest_lock: assert property (@(posedge i_clock) disable iff (i_reset)  // R16
    s_q.nest && wr && idx == IDX_SR && !i_core.ack && !i_core.restore
      |=> $stable(s_q.cpu_priority_level))
    else $error("level field written while nesting disabled");

  // Latch captures the vector presented a cycle earlier.
  a_latch_capture: assert property (@(posedge i_clock) disable iff (i_reset)  // R9 R10
    o_pend_valid |=> s_q.lat_vec == $past(o_pend_vec) && s_q.lat_lvl == $past(o_pend_level))
    else $error("pending latch missed the vector");

  // Leaving reset finds flags, enables and level at zero.
  a_reset_clear: assert property (@(posedge i_clock)  // R19
    $past(i_reset) && !i_reset |-> s_q.flag == '0 && s_q.en == '0 && cpu_level == 4'h0)
    else $error("state not cleared by reset");

  // Interrupt output follows enabled status bits.
  a_irq_level: assert property (@(posedge i_clock) disable iff (i_reset)
    o_irq == |(s_q.ev_stat & s_q.ev_en))
    else $error("interrupt output disagrees with status");

  // Every access phase ends with ready after one wait cycle.
  a_apb_ready: assert property (@(posedge i_clock) disable iff (i_reset)
    acc && !o_pready |=> o_pready)
    else $error("APB ready late");

  // A user vector comes only from a source that was flagged and enabled.
  a_enable_gate: assert property (@(posedge i_clock) disable iff (i_reset)  // R7 R18
    o_pend_valid && o_pend_vec >= VEC_OFFSET
      |-> 1'($past(live) >> (o_pend_vec - VEC_OFFSET)))
    else $error("user vector from a masked or idle source");

  // Presented trap vectors are one to five; zero, six and seven stay unused.
  a_trap_range: assert property (@(posedge i_clock) disable iff (i_reset)  // R2
    o_pend_valid && o_pend_vec < VEC_OFFSET |-> o_pend_vec >= 7'h01 && o_pend_vec <= 7'h05)
    else $error("reserved trap vector presented");

  // Level seven in the field, or the top bit set, holds back every user vector.
  a_user_masked: assert property (@(posedge i_clock) disable iff (i_reset)  // R14 R15
    s_q.cpu_priority_level == 3'h7 || s_q.ipl_msb |=> !(o_pend_valid && o_pend_vec >= VEC_OFFSET))
    else $error("user vector presented while user interrupts are off");

  // Accepting a vector raises the level to its priority while nesting is on.
  a_accept_level: assert property (@(posedge i_clock) disable iff (i_reset)  // R10 R15
    i_core.ack && s_q.pend_valid && !s_q.nest |=> cpu_level == $past(s_q.pend_lvl))
    else $error("level after acceptance differs from the presented priority");

  // Mapped registers answer cleanly; anything else ends with an error.
  a_slave_error: assert property (@(posedge i_clock) disable iff (i_reset)  // R3
    acc && !o_pready |=> o_pslverr == !($past(in_range) && $past(idx) <= IDX_EVCLR))
    else $error("APB error response disagrees with the register map");

  // With nothing pending the latch keeps its last capture.
  a_latch_hold: assert property (@(posedge i_clock) disable iff (i_reset)  // R9
    !o_pend_valid |=> $stable(s_q.lat_vec) && $stable(s_q.lat_lvl))
    else $error("pending latch changed with no vector presented");

endmodule
`default_nettype wire

// ==== vpic_core_model.sv ====
// Behavioural processor core that accepts presented vectors and restores levels.
`timescale 1ns/1ns
`default_nettype none
module vpic_core_model
  import vpic_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_pend_valid,
  input  wire logic       i_auto_ack,
  input  wire logic [1:0] i_delay,
  input  wire logic       i_restore,
  input  wire logic [3:0] i_restore_level,
  output var  vpic_core_s o_core
);
  logic [1:0] wait_q; // Cycles the presented vector has waited.
  logic       ack_q;  // One-cycle acceptance strobe.
  // Accept after a chosen wait, so the core can be prompt or slow; never twice.
  always_ff @(posedge i_clock) begin
    if (i_reset || !i_pend_valid || ack_q) begin
      wait_q <= 2'h0;
      ack_q  <= 1'b0;
    end else begin
      ack_q <= i_auto_ack && (wait_q == i_delay);
      if (wait_q != i_delay) begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
  // A level return from the bench passes straight through.
  assign o_core = '{ack_q, i_restore, i_restore_level};
endmodule
`default_nettype wire

// ==== vectored_priority_interrupt_ctrl_test.sv ====
// Self-checking bench for the vectored priority interrupt controller.
`timescale 1ns/1ns
`default_nettype none
module vectored_priority_interrupt_ctrl_test;
  import vpic_pkg::*;
  logic                 i_clock = 1'b0;
  logic                 i_reset = 1'b1;
  vpic_apb_s            bus     = '0;
  logic [SRC_COUNT-1:0] req     = '0;
  logic [4:0]           ext_pin = '0;
  logic [4:0]           trap    = '0;
  logic                 div0    = 1'b0;
  logic                 disi    = 1'b0;
  logic                 auto_ack = 1'b0;
  logic [1:0]           delay   = 2'h0;
  logic                 restore = 1'b0;
  logic [3:0]           restore_level = 4'h0;
  vpic_core_s           core;
  logic [31:0]          prdata;
  logic                 pready, pslverr, pend_valid, irq;
  logic [6:0]           pend_vec;
  logic [3:0]           pend_level, cpu_level;
  logic [23:0]          vector_addr;
  int                   mismatches = 0;
  int                   n_compared = 0;
  int                   cycles = 0;
  int                   seed = 32'hD00BA8E0;
  int                   n, p, t;
  logic                 alt;
  // Status bit of each trap vector one to five in control one.
  int                   trap_bit [5] = '{1, 3, 2, 4, 5};

  vpic_ctrl vpic_ctrl_i (.i_clock(i_clock), .i_reset(i_reset), .i_apb(bus), .i_req(req),
    .i_ext_pin(ext_pin), .i_trap(trap), .i_div_zero(div0), .i_disi_active(disi),
    .i_core(core), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_pend_valid(pend_valid), .o_pend_vec(pend_vec), .o_pend_level(pend_level),
    .o_vector_addr(vector_addr), .o_cpu_level(cpu_level), .o_irq(irq));
  vpic_core_model vpic_core_model_i (.i_clock(i_clock), .i_reset(i_reset),
    .i_pend_valid(pend_valid), .i_auto_ack(auto_ack), .i_delay(delay),
    .i_restore(restore), .i_restore_level(restore_level), .o_core(core));

  // Clock at 125 MHz.
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  // Cut a hang short.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge i_clock);
    bus <= '{1'b1, 1'b0, wr, {2'h0, idx, 2'h0}, wd};
    @(posedge i_clock);
    bus.penable <= 1'b1;
    // The request stands until the rising edge that samples pready high.
    do @(posedge i_clock); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    bus <= '0;
  endtask
  task automatic wrr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0, d, e);
    check(d, exp);
  endtask
  task automatic settle();
    repeat (8) @(posedge i_clock);
  endtask
  // Core return: one restore pulse with the given level, then settle.
  task automatic ret(input logic [3:0] lv);
    @(posedge i_clock);
    restore       <= 1'b1;
    restore_level <= lv;
    @(posedge i_clock);
    restore <= 1'b0;
    settle();
  endtask
  task automatic reset_dut();
    @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
  endtask
  // Enable and give a priority to one user source, then pulse its request to set its flag.
  task automatic arm(input int s, input int pr);
    wrr(IDX_EN0 + 8'(s / 16), 32'h1 << (s % 16));
    wrr(IDX_PRIO0 + 8'(s / 4), pr << (4 * (s % 4)));
    @(posedge i_clock);
    req[s] <= 1'b1;
    @(posedge i_clock);
    req <= '0;
  endtask
  // Table address of a vector in either table.
  function automatic logic [23:0] vaddr(input int v, input logic a);
    return IVT_BASE + 24'(2 * v) + (a ? ALT_OFFSET : 24'h0);
  endfunction

  initial begin
    logic [31:0] d;
    logic        e;
    reset_dut();
    for (int i = 0; i <= 8'h23; i++) rdc(8'(i), 32'h0);
    apb(1'b0, 8'h24, 32'h0, d, e);
    check(e, 1'b1);
    wrr(IDX_CORE, 32'h8);
    rdc(IDX_CORE, 32'h0);
    wrr(IDX_SR, 32'hE0);
    rdc(IDX_SR, 32'hE0);
    arm(3, 7);
    settle();
    check(pend_valid, 1'b0);
    wrr(IDX_GC1, 32'h8000);
    wrr(IDX_SR, 32'h20);
    rdc(IDX_SR, 32'hE0);
    // Random user sources, random table, random core response time.
    for (int k = 0; k < 8; k++) begin
      reset_dut();
      do n = $unsigned($random(seed)) % SRC_COUNT;
      while (n inside {0, 20, 29, 53, 54, 15, 18, 45, [57:60], [62:64], 67});
      p = 1 + $unsigned($random(seed)) % 7;
      alt = 1'($random(seed));
      delay <= 2'($random(seed));
      wrr(IDX_GC2, 32'(alt) << 15);
      arm(n, p);
      settle();
      check(pend_vec, n + 8);
      check(pend_level, p);
      check(vector_addr, vaddr(n + 8, alt));
      rdc(IDX_FLAG0 + 8'(n / 16), 32'h1 << (n % 16));
      auto_ack <= 1'b1;
      settle();
      auto_ack <= 1'b0;
      rdc(IDX_PEND, (p << 8) | (n + 8));
      check(cpu_level, p);
      check(pend_valid, 1'b0);
      wrr(IDX_FLAG0 + 8'(n / 16), 32'h0);
      wrr(IDX_FLAG0 + 8'(n / 16), 32'hFFFF);
      rdc(IDX_FLAG0 + 8'(n / 16), 32'h0);
    end
    // Equal priorities: lower request number wins, only above the level.
    reset_dut();
    wrr(IDX_SR, 32'h80);
    arm(40, 4);
    arm(1, 4);
    settle();
    check(pend_valid, 1'b0);
    wrr(IDX_SR, 32'h60);
    settle();
    check(pend_vec, 7'd9);
    wrr(IDX_EN0, 32'h0);
    settle();
    check(pend_vec, 7'd48);
    // Every trap beats level 7, then its level masks user sources.
    for (t = 0; t < 5; t++) begin
      reset_dut();
      wrr(IDX_SR, 32'hE0);
      @(posedge i_clock);
      trap[t] <= 1'b1;
      div0 <= (t == 3);
      @(posedge i_clock);
      trap <= '0;
      div0 <= 1'b0;
      settle();
      check(pend_vec, t + 1);
      check(vector_addr, vaddr(t + 1, 1'b0));
      rdc(IDX_GC1, (32'h1 << trap_bit[t]) | (t == 3 ? 32'h40 : 32'h0));
      auto_ack <= 1'b1;
      settle();
      auto_ack <= 1'b0;
      check(cpu_level, 15 - t);
      wrr(IDX_GC1, 32'h0);
      arm(3, 7);
      settle();
      check(pend_valid, 1'b0);
      ret(4'h0);
      check(pend_vec, 7'd11);
      ret(4'hF);
      check(cpu_level, 4'h7);
    end
    // External pin zero, event status, masking and clearing of the interrupt.
    reset_dut();
    disi <= 1'b1;
    rdc(IDX_GC2, 32'h4000);
    wrr(IDX_EVEN, 32'h1);
    arm(0, 3);
    ext_pin <= 5'h01;
    settle();
    check(pend_vec, 7'd8);
    check(irq, 1'b1);
    rdc(IDX_EVST, 32'h1);
    wrr(IDX_EVEN, 32'h0);
    settle();
    check(irq, 1'b0);
    wrr(IDX_EVCLR, 32'h1);
    rdc(IDX_EVST, 32'h0);
    wrr(IDX_EVEN, 32'h1);
    settle();
    check(irq, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
